// ==== include/aosp_pkg.sv ====
// Shared constants and carrier types for the arbitrary-order polling decoder
`default_nettype none
package aosp_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] REG_TICK_IDX    = 8'h01;
	localparam logic [7:0] REG_STATUS_IDX  = 8'h02;
	localparam logic [7:0] REG_HELD_IDX    = 8'h03;
	localparam logic [7:0] REG_CFG_C_IDX   = 8'h09;
	localparam logic [7:0] REG_OUTCFG_IDX  = 8'h14;

	// ==========================================================
	// Field positions
	localparam int TICK_LEN_LSB    = 0;
	localparam int TICK_LEN_W      = 12;
	localparam int NODE_LSB        = 16;
	localparam int LBIST_DIS_BIT   = 0;
	localparam int COIL_DIS_BIT    = 1;
	localparam int NO_SAMPLE_BIT   = 0;
	localparam int SAMPLE_ADR_BIT  = 1;
	localparam int DIAG_ADR_BIT    = 2;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_HELD_BIT     = 1;
	localparam int ST_ID_LSB       = 2;
	localparam int ST_FUNC_LSB     = 4;
	localparam int ST_LEVEL_LSB    = 8;

	// ==========================================================
	// Reset values
	localparam logic [11:0] TICK_LEN_RST = 12'h12C;
	localparam logic [1:0]  NODE_RST     = 2'h0;
	localparam logic [1:0]  CFG_C_RST    = 2'h0;
	localparam logic [2:0]  OUTCFG_RST   = 3'h0;

	// ==========================================================
	// Pulse lengths in ticks
	localparam logic [7:0] OUT_MIN      = 8'h0F;
	localparam logic [7:0] OUT_MAX      = 8'h13;
	localparam logic [7:0] SMP_MIN      = 8'h1F;
	localparam logic [7:0] SMP_MAX      = 8'h27;
	localparam logic [7:0] DIAG_MIN     = 8'h38;
	localparam logic [7:0] DIAG_MAX     = 8'h46;
	localparam logic [7:0] INC_MIN      = 8'h01;
	localparam logic [7:0] INC_MAX      = 8'h04;
	localparam logic [7:0] ID_END_TICKS = 8'h12;
	localparam logic [7:0] SYNC_TICKS   = 8'h38;
	localparam logic [1:0] ID_MAX       = 2'h3;

	// ==========================================================
	// Reply timing
	localparam real         CLK_PERIOD_NS   = 10.0;
	localparam real         T_REPLY_MIN_US  = 70.4;
	localparam int unsigned REPLY_MIN_CYC   =
		int'($ceil(T_REPLY_MIN_US * 1000.0 / CLK_PERIOD_NS));

	localparam int MEAS_W = 16;

	typedef enum logic [1:0] {
		FN_NONE   = 2'h0,
		FN_OUTPUT = 2'h1,
		FN_SAMPLE = 2'h2,
		FN_DIAG   = 2'h3
	} aosp_func_t;

	typedef struct packed {
		logic              from_hold;
		logic [1:0]        node;
		logic [MEAS_W-1:0] data;
	} aosp_reply_t;

	typedef struct packed {
		logic start;
		logic lbist_en;
		logic coil_en;
	} aosp_diag_t;

endpackage
`default_nettype wire

// ==== src/aosp_fifo.sv ====
// Small valid/ready FIFO holding reply words for the frame generator
`default_nettype none
module aosp_fifo #(
	parameter int W     = 19,
	parameter int DEPTH = 4
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [W-1:0]           in_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [W-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]  level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CW'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end

endmodule
`default_nettype wire

// ==== src/aosp_decoder.sv ====
// Arbitrary-order polling decoder: pulse classifier, id counter, APB registers
// ==========================================================
// How it works
// - After an addressing pulse the host sends 0 to 3 short id increment pulses and we count them.
// - A high line of 18 ticks after the last increment pulse closes the id sequence.
// - A reply is held back until 70.4 us will have passed from the function pulse rise to the end of sync.
// - Only the node whose number equals the counted increments replies; all others stay silent.
// - An output request replies with held data if any exists, otherwise with freshly sampled data.
// - With hold bypass set, nothing is ever held and replies always carry fresh data.
// - A sample pulse latches the measurement at its rising edge unless hold bypass is set.
// - Sample addressing 0 makes the sample pulse broadcast with no reply; 1 also addresses a node.
// - A self-test pulse starts diagnostics; logic and coil tests each have a disable bit.
// - Diag addressing 0 starts tests at once on all nodes, 1 only on the addressed node, never replying.
// - Low lengths 15-19, 31-39 and 56-70 ticks select output, sample and self-test.
`default_nettype none
module aosp_decoder #(
	parameter int unsigned FIFO_DEPTH    = 4,
	parameter int unsigned REPLY_MIN_CYC = aosp_pkg::REPLY_MIN_CYC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        sent_in,
	input  wire logic [aosp_pkg::MEAS_W-1:0] meas_data,
	output logic                             reply_valid,
	input  wire logic                        reply_ready,
	output aosp_pkg::aosp_reply_t            reply_word,
	output aosp_pkg::aosp_diag_t             diag_req
);

	// ==========================================================
	// Types and addresses
	typedef enum logic [4:0] {
		ST_IDLE     = 5'b00001,
		ST_FUNC_LOW = 5'b00010,
		ST_ID_GAP   = 5'b00100,
		ST_ID_LOW   = 5'b01000,
		ST_REPLY    = 5'b10000
	} aosp_state_t;

	localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [7:0] A_TICK   = {aosp_pkg::REG_TICK_IDX[5:0], 2'b00};
	localparam logic [7:0] A_STATUS = {aosp_pkg::REG_STATUS_IDX[5:0], 2'b00};
	localparam logic [7:0] A_HELD   = {aosp_pkg::REG_HELD_IDX[5:0], 2'b00};
	localparam logic [7:0] A_CFG_C  = {aosp_pkg::REG_CFG_C_IDX[5:0], 2'b00};
	localparam logic [7:0] A_OUTCFG = {aosp_pkg::REG_OUTCFG_IDX[5:0], 2'b00};

	// ==========================================================
	// Configuration registers
	logic [11:0]                 tick_len_q;
	logic [1:0]                  node_q;
	logic                        lbist_dis_q;
	logic                        coil_dis_q;
	logic                        no_sample_q;
	logic                        sample_adr_q;
	logic                        diag_adr_q;
	logic                        wr_en;

	assign wr_en = psel & penable & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_len_q   <= aosp_pkg::TICK_LEN_RST;
			node_q       <= aosp_pkg::NODE_RST;
			lbist_dis_q  <= aosp_pkg::CFG_C_RST[0];
			coil_dis_q   <= aosp_pkg::CFG_C_RST[1];
			no_sample_q  <= aosp_pkg::OUTCFG_RST[0];
			sample_adr_q <= aosp_pkg::OUTCFG_RST[1];
			diag_adr_q   <= aosp_pkg::OUTCFG_RST[2];
		end else if (wr_en) begin
			unique case (paddr)
				A_TICK: begin
					// A zero tick length would stall the prescaler
					tick_len_q <= (pwdata[11:0] == 12'h000) ? 12'h001 : pwdata[11:0];
					node_q     <= pwdata[aosp_pkg::NODE_LSB +: 2];
				end
				A_CFG_C: begin
					lbist_dis_q <= pwdata[aosp_pkg::LBIST_DIS_BIT];
					coil_dis_q  <= pwdata[aosp_pkg::COIL_DIS_BIT];
				end
				A_OUTCFG: begin
					no_sample_q  <= pwdata[aosp_pkg::NO_SAMPLE_BIT];
					sample_adr_q <= pwdata[aosp_pkg::SAMPLE_ADR_BIT];
					diag_adr_q   <= pwdata[aosp_pkg::DIAG_ADR_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Line synchroniser and edges
	logic line_s1_q;
	logic line_s2_q;
	logic line_q;
	logic fall_w;
	logic rise_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			line_q    <= 1'b1;
		end else begin
			line_s1_q <= sent_in;
			line_s2_q <= line_s1_q;
			line_q    <= line_s2_q;
		end
	end

	assign fall_w = line_q & ~line_s2_q;
	assign rise_w = ~line_q & line_s2_q;

	// ==========================================================
	// Tick prescaler, restarted on every edge so lengths are whole ticks
	logic [11:0] pre_q;
	logic [7:0]  ticks_q;
	logic        tick_w;

	assign tick_w = (pre_q == tick_len_q - 12'h001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q   <= 12'h000;
			ticks_q <= 8'h00;
		end else if (fall_w || rise_w) begin
			pre_q   <= 12'h000;
			ticks_q <= 8'h00;
		end else if (tick_w) begin
			pre_q <= 12'h000;
			if (ticks_q != 8'hFF) begin
				ticks_q <= ticks_q + 8'h01;
			end
		end else begin
			pre_q <= pre_q + 12'h001;
		end
	end

	// ==========================================================
	// Pulse classification
	aosp_pkg::aosp_func_t func_w;
	logic                 inc_ok_w;
	logic [7:0]           ticks_now_w;

	function automatic logic in_rng(input logic [7:0] t, input logic [7:0] lo, input logic [7:0] hi);
		in_rng = (t >= lo) && (t <= hi);
	endfunction

	// Count the tick ending on this edge, else exact lengths read one short
	assign ticks_now_w = (tick_w && ticks_q != 8'hFF) ? ticks_q + 8'h01 : ticks_q;

	always_comb begin
		func_w = aosp_pkg::FN_NONE;
		if (in_rng(ticks_now_w, aosp_pkg::OUT_MIN, aosp_pkg::OUT_MAX)) begin
			func_w = aosp_pkg::FN_OUTPUT;
		end else if (in_rng(ticks_now_w, aosp_pkg::SMP_MIN, aosp_pkg::SMP_MAX)) begin
			func_w = aosp_pkg::FN_SAMPLE;
		end else if (in_rng(ticks_now_w, aosp_pkg::DIAG_MIN, aosp_pkg::DIAG_MAX)) begin
			func_w = aosp_pkg::FN_DIAG;
		end
	end

	assign inc_ok_w = in_rng(ticks_now_w, aosp_pkg::INC_MIN, aosp_pkg::INC_MAX);

	// ==========================================================
	// Sequencer
	aosp_state_t          state_q;
	aosp_pkg::aosp_func_t last_func_q;
	logic [1:0]           id_cnt_q;
	logic                 is_diag_q;
	logic [15:0]          since_q;
	logic [31:0]          ready_at_w;
	logic                 time_ok_w;
	logic                 push_w;
	logic                 fifo_in_ready;
	logic                 diag_ok_w;
	logic                 func_rise_w;

	assign func_rise_w = (state_q == ST_FUNC_LOW) && rise_w;
	assign diag_ok_w   = !(lbist_dis_q && coil_dis_q);
	// Sync end lies SYNC_TICKS after the frame start we release
	assign ready_at_w  = 32'(since_q) + 32'(aosp_pkg::SYNC_TICKS) * 32'(tick_len_q);
	assign time_ok_w   = (ready_at_w >= REPLY_MIN_CYC);
	assign push_w      = (state_q == ST_REPLY) && time_ok_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q <= 16'h0000;
		end else if (func_rise_w) begin
			since_q <= 16'h0000;
		end else if (since_q != 16'hFFFF) begin
			since_q <= since_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= ST_IDLE;
			id_cnt_q    <= 2'h0;
			is_diag_q   <= 1'b0;
			last_func_q <= aosp_pkg::FN_NONE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (fall_w) begin
						state_q <= ST_FUNC_LOW;
					end
				end
				ST_FUNC_LOW: begin
					if (rise_w) begin
						// Out-of-range lows leave the status of the last poll alone
						if (func_w != aosp_pkg::FN_NONE) begin
							last_func_q <= func_w;
							id_cnt_q    <= 2'h0;
							is_diag_q   <= (func_w == aosp_pkg::FN_DIAG);
						end
						unique case (func_w)
							aosp_pkg::FN_OUTPUT: state_q <= ST_ID_GAP;
							aosp_pkg::FN_SAMPLE: state_q <= sample_adr_q ? ST_ID_GAP : ST_IDLE;
							aosp_pkg::FN_DIAG:   state_q <= (diag_adr_q && diag_ok_w) ? ST_ID_GAP : ST_IDLE;
							aosp_pkg::FN_NONE:   state_q <= ST_IDLE;
						endcase
					end
				end
				ST_ID_GAP: begin
					if (fall_w) begin
						state_q <= ST_ID_LOW;
					end else if (ticks_q >= aosp_pkg::ID_END_TICKS) begin
						if (id_cnt_q != node_q) begin
							state_q <= ST_IDLE;
						end else begin
							state_q <= is_diag_q ? ST_IDLE : ST_REPLY;
						end
					end
				end
				ST_ID_LOW: begin
					if (rise_w) begin
						state_q <= ST_ID_GAP;
						if (inc_ok_w && id_cnt_q != aosp_pkg::ID_MAX) begin
							id_cnt_q <= id_cnt_q + 2'h1;
						end
					end
				end
				ST_REPLY: begin
					// A full FIFO stalls here until the frame side drains it
					if (push_w && fifo_in_ready) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Sample and hold
	logic [aosp_pkg::MEAS_W-1:0] held_q;
	logic                        held_valid_q;
	logic                        latch_w;
	logic                        use_hold_w;

	assign latch_w    = func_rise_w && (func_w == aosp_pkg::FN_SAMPLE) && !no_sample_q;
	assign use_hold_w = held_valid_q && !no_sample_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_q       <= '0;
			held_valid_q <= 1'b0;
		end else if (latch_w) begin
			held_q       <= meas_data;
			held_valid_q <= 1'b1;
		end else if (push_w && fifo_in_ready) begin
			held_valid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Reply FIFO towards the frame generator
	aosp_pkg::aosp_reply_t in_word_w;
	logic [LVL_W-1:0]      level_w;

	always_comb begin
		in_word_w.from_hold = use_hold_w;
		in_word_w.node      = node_q;
		in_word_w.data      = use_hold_w ? held_q : meas_data;
	end

	aosp_fifo #(
		.W     ($bits(aosp_pkg::aosp_reply_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (push_w),
		.in_ready  (fifo_in_ready),
		.in_data   (in_word_w),
		.out_valid (reply_valid),
		.out_ready (reply_ready),
		.out_data  (reply_word),
		.level     (level_w)
	);

	// ==========================================================
	// Self-test request
	logic diag_fire_w;

	assign diag_fire_w = diag_ok_w && (
		(func_rise_w && func_w == aosp_pkg::FN_DIAG && !diag_adr_q) ||
		(state_q == ST_ID_GAP && is_diag_q && !fall_w &&
		 ticks_q >= aosp_pkg::ID_END_TICKS && id_cnt_q == node_q));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_req <= '0;
		end else begin
			diag_req.start    <= diag_fire_w;
			diag_req.lbist_en <= diag_fire_w && !lbist_dis_q;
			diag_req.coil_en  <= diag_fire_w && !coil_dis_q;
		end
	end

	// ==========================================================
	// APB read side, answered in the access phase without wait states
	logic [31:0] rdata_d;
	logic        err_d;
	logic [31:0] status_w;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[aosp_pkg::ST_BUSY_BIT]       = (state_q != ST_IDLE);
		status_w[aosp_pkg::ST_HELD_BIT]       = held_valid_q;
		status_w[aosp_pkg::ST_ID_LSB +: 2]    = id_cnt_q;
		status_w[aosp_pkg::ST_FUNC_LSB +: 2]  = last_func_q;
		status_w[aosp_pkg::ST_LEVEL_LSB +: LVL_W] = level_w;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d   = 1'b0;
		unique case (paddr)
			A_TICK:   rdata_d = {14'h0000, node_q, 4'h0, tick_len_q};
			A_STATUS: rdata_d = status_w;
			A_HELD:   rdata_d = 32'(held_q);
			A_CFG_C:  rdata_d = {30'h0000_0000, coil_dis_q, lbist_dis_q};
			A_OUTCFG: rdata_d = {29'h0000_0000, diag_adr_q, sample_adr_q, no_sample_q};
			default:  err_d   = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
			pslverr <= err_d;
		end
	end

	assign pready = 1'b1;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_id_count_step: assert property (
		(state_q == ST_ID_LOW && rise_w && inc_ok_w && id_cnt_q != aosp_pkg::ID_MAX)
		|=> id_cnt_q == $past(id_cnt_q) + 2'h1) else $error("id count did not step");

	a_gap_end: assert property (
		(state_q == ST_ID_GAP && !fall_w && ticks_q >= aosp_pkg::ID_END_TICKS)
		|=> state_q != ST_ID_GAP) else $error("id gap did not close");

	a_gap_wait: assert property (
		(state_q == ST_ID_GAP && !fall_w && ticks_q < aosp_pkg::ID_END_TICKS)
		|=> state_q == ST_ID_GAP) else $error("id gap closed early");

	a_reply_time: assert property (
		(state_q == ST_REPLY &&
		 32'(since_q) + 32'(aosp_pkg::SYNC_TICKS) * 32'(tick_len_q) < REPLY_MIN_CYC)
		|=> state_q == ST_REPLY) else $error("reply released too soon");

	a_only_match: assert property (
		(push_w && fifo_in_ready) |-> id_cnt_q == node_q) else $error("reply to foreign id");

	a_held_used: assert property (
		(push_w && fifo_in_ready && held_valid_q && !no_sample_q)
		|-> in_word_w.data == held_q ##1 !held_valid_q) else $error("held data not used once");

	a_bypass_hold: assert property (
		no_sample_q |=> !$rose(held_valid_q)) else $error("hold taken in bypass");

	a_sample_latch: assert property (
		(func_rise_w && func_w == aosp_pkg::FN_SAMPLE && !no_sample_q)
		|=> held_valid_q && held_q == $past(meas_data)) else $error("sample not latched");

	a_sample_bcast: assert property (
		(func_rise_w && func_w == aosp_pkg::FN_SAMPLE && !sample_adr_q)
		|=> state_q == ST_IDLE) else $error("broadcast sample answered");

	a_diag_off: assert property (
		diag_req.start |-> !($past(lbist_dis_q) && $past(coil_dis_q))) else $error("diag with both tests off");

	a_diag_bcast: assert property (
		(func_rise_w && func_w == aosp_pkg::FN_DIAG && !diag_adr_q && diag_ok_w)
		|=> diag_req.start ##1 !diag_req.start) else $error("broadcast diag missing");

	a_ignore_pulse: assert property (
		(func_rise_w && func_w == aosp_pkg::FN_NONE) |=> state_q == ST_IDLE) else $error("bad pulse acted on");

	c_output_reply: cover property (last_func_q == aosp_pkg::FN_OUTPUT && push_w && fifo_in_ready);
	c_sample_reply: cover property (last_func_q == aosp_pkg::FN_SAMPLE && push_w && use_hold_w);
	c_diag_addr:    cover property (is_diag_q && diag_req.start);
	c_fifo_stall:   cover property (push_w && !fifo_in_ready);

endmodule
`default_nettype wire

// ==== bench/aosp_host.sv ====
// Host model that polls nodes over the shared single-wire line
`default_nettype none
module aosp_host (
	input  wire logic pclk,
	output logic      sent_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Line driver
	int tick_len = 4;
	int cyc = 0;
	int func_rise = 0;

	initial sent_in = 1'h1;

	always @(posedge pclk) begin
		cyc <= cyc + 1;
	end

	task automatic low_for(input int ticks);
		@(posedge pclk);
		sent_in <= 1'h0;
		repeat (ticks * tick_len) @(posedge pclk);
		sent_in <= 1'h1;
	endtask

	task automatic poll(input int ticks, input int id);
		low_for(ticks);
		func_rise = cyc;
		for (int i = 0; i < id; i++) begin
			repeat (3 * tick_len) @(posedge pclk);
			low_for(2);
		end
		// Long enough high to close the id sequence
		repeat (25 * tick_len) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== bench/test_arbitrary_order_sent_poll_decoder.sv ====
// Self-checking bench for the arbitrary-order polling decoder
`default_nettype none
module test_arbitrary_order_sent_poll_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Signals and instances
	localparam int RCYC = 600;
	logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                        sent_in, reply_valid, reply_ready, prev_valid, err;
	logic [7:0]                  paddr;
	logic [31:0]                 pwdata, prdata, rd;
	logic [aosp_pkg::MEAS_W-1:0] meas_data, held;
	int                          mismatches, tests_run, seed, node, allow, rmode;
	int                          lens[4] = '{15, 19, 17, 16};
	aosp_pkg::aosp_reply_t       reply_word;
	aosp_pkg::aosp_diag_t        diag_req;
	aosp_pkg::aosp_reply_t       exp_q[$];
	logic [1:0]                  diag_q[$];

	aosp_decoder #(.FIFO_DEPTH(4), .REPLY_MIN_CYC(RCYC)) aosp_decoder_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sent_in(sent_in), .meas_data(meas_data), .reply_valid(reply_valid),
		.reply_ready(reply_ready), .reply_word(reply_word), .diag_req(diag_req));
	aosp_host aosp_host_i (.pclk(pclk), .sent_in(sent_in));

	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========
	// Monitor: replies, reply timing, diag requests, timeout
	always @(posedge pclk) begin
		if (aosp_host_i.cyc > 80000) begin
			mismatches++;
			conclude();
		end
		if (reply_valid === 1'h1 && prev_valid !== 1'h1)
			check(aosp_host_i.cyc - aosp_host_i.func_rise >= RCYC - 228, 1);
		prev_valid <= reply_valid;
		if (reply_valid === 1'h1 && reply_ready === 1'h1) begin
			check(exp_q.size() > 0, 1);
			if (exp_q.size() > 0)
				check(reply_word, exp_q.pop_front());
		end
		if (diag_req.start === 1'h1)
			diag_q.push_back({diag_req.lbist_en, diag_req.coil_en});
		// Random stalls mimic a busy frame generator
		reply_ready <= (rmode == 0) ? 1'h1 : (rmode == 1) ? 1'h0 : 1'($random(seed));
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Ends once pready is high; only the bench timeout bounds this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(rd, e);
	endtask

	// Fresh measurement per poll; expectation built before the pulse goes out
	task automatic poll(input int t, input int id, input logic lat, input logic hold, input logic rep);
		aosp_pkg::aosp_reply_t r;
		logic [15:0] m;
		int n = 0;
		m = 16'($random(seed));
		@(posedge pclk);
		meas_data <= m;
		if (lat)
			held = m;
		r.from_hold = hold;
		r.node = 2'(node);
		r.data = hold ? held : m;
		if (rep)
			exp_q.push_back(r);
		aosp_host_i.poll(t, id);
		repeat (400) @(posedge pclk);
		while (exp_q.size() > allow && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		check(exp_q.size() <= allow, 1);
	endtask

	// ==========
	// Main sequence
	initial begin
		seed = 32'h1F86459E;
		{presetn, psel, penable, pwrite, prev_valid} = 5'h0;
		{paddr, pwdata, meas_data, held} = 72'h0;
		reply_ready = 1'h1;
		{rmode, allow, mismatches, tests_run} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rchk(8'h04, 32'h0000012C);
		rchk(8'h24, 32'h0);
		rchk(8'h50, 32'h0);
		rchk(8'h08, 32'h0);
		apb(1'h0, 8'h10, 32'h0);
		check(err, 1'h1);
		check(rd, 32'h0);
		node = $random(seed) & 3;
		apb(1'h1, 8'h04, (node << 16) | 4);
		rchk(8'h04, (node << 16) | 4);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			poll(lens[i], i, 1'h0, 1'h0, i == node);
			rchk(8'h08, (i << 2) | 32'h10);
		end
		foreach (lens[i])
			poll(10 * i + 20, node, 1'h0, 1'h0, 1'h0);
		poll(80, node, 1'h0, 1'h0, 1'h0);
		$display("test output addressing done");
		poll(35, node, 1'h1, 1'h0, 1'h0);
		rchk(8'h0C, {16'h0, held});
		poll(17, node, 1'h0, 1'h1, 1'h1);
		poll(17, node, 1'h0, 1'h0, 1'h1);
		apb(1'h1, 8'h50, 32'h2);
		poll(31, node ^ 1, 1'h1, 1'h0, 1'h0);
		poll(39, node, 1'h1, 1'h1, 1'h1);
		poll(17, node, 1'h0, 1'h0, 1'h1);
		apb(1'h1, 8'h50, 32'h1);
		poll(35, node, 1'h0, 1'h0, 1'h0);
		poll(17, node, 1'h0, 1'h0, 1'h1);
		$display("test sample and hold done");
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 4; k++) begin
				apb(1'h1, 8'h24, c);
				apb(1'h1, 8'h50, (k & 2) << 1);
				poll(56 + 14 * (k & 1), node ^ (k & 1), 1'h0, 1'h0, 1'h0);
				check(diag_q.size(), (c != 3 && (k < 2 || k == 2)) ? 1 : 0);
				if (diag_q.size() > 0)
					check(diag_q.pop_front(), {!c[0], !c[1]});
				diag_q.delete();
			end
		$display("test self-test done");
		apb(1'h1, 8'h50, 32'h0);
		rmode = 1;
		allow = 4;
		repeat (4) poll(17, node, 1'h0, 1'h0, 1'h1);
		rchk(8'h08, 32'h410 | (node << 2));
		rmode = 2;
		allow = 0;
		poll(10, node, 1'h0, 1'h0, 1'h0);
		rchk(8'h08, 32'h10 | (node << 2));
		$display("test reply buffer done");
		conclude();
	end
endmodule
`default_nettype wire
